// *** rtl/red_decoder.sv ***
// rotary encoder / pushbutton step decoder with position counter
`default_nettype none
//
// Operation
// [RULE_01] push every switch-state change into history
// [RULE_02] check last three states after each change
// [RULE_03] four valid three-state sequences per direction
// [RULE_04] modes 2,3: one sequence pair, lowest resolution
// [RULE_05] mode 1: two sequence pairs, middle resolution
// [RULE_06] mode 5: all sequences, highest resolution
// [RULE_07] mode 4: inputs are up/down pushbuttons
// [RULE_08] sequences suppress up/down oscillation at detent
// [RULE_09] synchronise both inputs before change detection
// [RULE_10] one-cycle pulse and signed position adjust

module red_decoder
(
  input  wire logic                       ref_clk_i, // 25 MHz
  input  wire logic                       rst_i,     // sync, high
  input  wire logic                       sw_a_i,    // switch a / up
  input  wire logic                       sw_b_i,    // switch b / down
  input  wire logic [2:0]                 mode_i,    // resolution
  output var  red_pkg::red_step_s         step_o,    // step pulses
  output var  logic [red_pkg::RED_POS_W-1:0] pos_o   // signed position
);
  import red_pkg::*;

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  // three stages; a change counts once stages 2 and 3 agree, so
  // stage 1 feeds only stage 2 and metastability never reaches logic
  red_sw_t sync1_reg, sync2_reg, sync3_reg;
  red_sw_t sync1_next, sync2_next, sync3_next;
  red_sw_t stab_reg, stab_next;    // debounced-by-agreement state

  always_comb
  begin
    sync1_next = {sw_b_i, sw_a_i};  // see [RULE_09]
    sync2_next = sync1_reg;
    sync3_next = sync2_reg;
    stab_next  = stab_reg;
    if (sync2_reg == sync3_reg)
    begin
      stab_next = sync3_reg;        // see [RULE_09]
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= RED_SW_RST;
      sync2_reg <= RED_SW_RST;
      sync3_reg <= RED_SW_RST;
      stab_reg  <= RED_SW_RST;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
      stab_reg  <= stab_next;
    end
  end

  // ----------------------------------------------------------------
  // cyclic history and sequence matching
  // ----------------------------------------------------------------
  // gray position of a state around the switch cycle 0,1,3,2
  function automatic logic [1:0] red_phase(input red_sw_t s);
    unique case (s)
      2'h0: red_phase = 2'h0;
      2'h1: red_phase = 2'h1;
      2'h3: red_phase = 2'h2;
      2'h2: red_phase = 2'h3;
    endcase
  endfunction

  red_sw_t   hist_reg [3];          // [0] newest, [2] oldest
  red_sw_t   hist_next [3];
  logic      chg_reg, chg_next;     // change seen last cycle, outside button mode
  red_step_s step_next;
  logic [RED_POS_W-1:0] pos_reg, pos_next;

  logic [1:0] p0, p1, p2;           // phases of newest..oldest
  logic       seq_up, seq_dn;       // clean three-state sequence
  logic       sel_ok;               // sequence end phase selected
  logic       chg_now;              // new stable state differs

  always_comb
  begin
    chg_now   = (stab_reg != hist_reg[0]);
    for (int i = 0; i < 3; i++)
    begin
      hist_next[i] = hist_reg[i];
    end
    if (chg_now)
    begin
      hist_next[0] = stab_reg;      // see [RULE_01]
      hist_next[1] = hist_reg[0];
      hist_next[2] = hist_reg[1];
    end
    chg_next = chg_now && (mode_i != RED_MODE_BTN);

    p0 = red_phase(hist_reg[0]);
    p1 = red_phase(hist_reg[1]);
    p2 = red_phase(hist_reg[2]);
    // two steps the same way; a back-and-forth pattern matches
    // neither, so a bouncing detent switch gives no count
    seq_up = (p1 == 2'(p2 + 2'h1)) && (p0 == 2'(p1 + 2'h1)); // see [RULE_03]
    seq_dn = (p1 == 2'(p2 - 2'h1)) && (p0 == 2'(p1 - 2'h1)); // see [RULE_08]

    // the end phase decides which of the four sequences counts
    unique case (mode_i)
      RED_MODE_LOW2, RED_MODE_LOW3:
        sel_ok = (p0 == 2'h0);       // see [RULE_04]
      RED_MODE_MID:
        sel_ok = (p0[0] == 1'b0);    // see [RULE_05]
      RED_MODE_HIGH:
        sel_ok = 1'b1;               // see [RULE_06]
      default:
        sel_ok = 1'b0;               // illegal codes and button mode
    endcase

    step_next = '0;
    if (mode_i == RED_MODE_BTN)
    begin
      // press pulls a line low; count on the press edge only
      step_next.up   = chg_now && hist_reg[0][0] && !stab_reg[0]; // see [RULE_07]
      step_next.down = chg_now && hist_reg[0][1] && !stab_reg[1]; // see [RULE_07]
    end
    else if (chg_reg && sel_ok)
    begin
      step_next.up   = seq_up;       // see [RULE_02]
      step_next.down = seq_dn;       // see [RULE_02]
    end

    pos_next = pos_reg;
    if (step_next.up)
    begin
      pos_next = RED_POS_W'(pos_reg + 1'b1); // see [RULE_10]
    end
    else if (step_next.down)
    begin
      pos_next = RED_POS_W'(pos_reg - 1'b1); // see [RULE_10]
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 3; i++)
      begin
        hist_reg[i] <= RED_SW_RST;
      end
      chg_reg <= 1'b0;
      step_o  <= '0;
      pos_reg <= RED_POS_RST;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        hist_reg[i] <= hist_next[i];
      end
      chg_reg <= chg_next;
      step_o  <= step_next;
      pos_reg <= pos_next;
    end
  end

  assign pos_o = pos_reg;           // straight from the flip-flop

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_change;
    stab_reg != hist_reg[0];
  endsequence

  hist_push_a: assert property (s_change |=> hist_reg[0] == $past(stab_reg)
    && hist_reg[1] == $past(hist_reg[0])) // see [RULE_01]
    else $error("history not updated on change");
  step_excl_a: assert property (!(step_o.up && step_o.down)) // see [RULE_08]
    else $error("up and down together");
  step_cause_a: assert property ((step_o.up || step_o.down) |->
    $past(chg_reg) || $past(mode_i) == RED_MODE_BTN) // see [RULE_02]
    else $error("step without a change");
  pos_up_a: assert property (step_o.up |-> pos_o == $past(pos_o) + 1'b1) // see [RULE_10]
    else $error("position not incremented");
  pos_dn_a: assert property (step_o.down |-> pos_o == $past(pos_o) - 1'b1) // see [RULE_10]
    else $error("position not decremented");
  pos_hold_a: assert property (!(step_o.up || step_o.down) |->
    $stable(pos_o)) // see [RULE_10]
    else $error("position moved without a step");
  low_res_a: assert property (step_o.up && $past(mode_i, 2) == RED_MODE_LOW2
    && $past(mode_i) == RED_MODE_LOW2 |-> $past(p0) == 2'h0) // see [RULE_04]
    else $error("low resolution counted off phase");
  mid_res_a: assert property (step_o.down && $past(mode_i) == RED_MODE_MID
    |-> $past(p0[0]) == 1'b0) // see [RULE_05]
    else $error("middle resolution counted off phase");
  sync_lag_a: assert property ($changed(stab_reg) |->
    $past(sync2_reg) == $past(sync3_reg)) // see [RULE_09]
    else $error("state taken before stages agree");
  pulse_one_a: assert property (step_o.up && $past(mode_i) != RED_MODE_BTN
    |=> !step_o.up) // see [RULE_10]
    else $error("up pulse longer than one cycle");

endmodule // red_decoder

`default_nettype wire

// *** rtl/red_pkg.sv ***
// package for the rotary encoder decoder: modes, timing, carriers
`default_nettype none

package red_pkg;

  // ----------------------------------------------------------------
  // mode settings
  // ----------------------------------------------------------------
  localparam logic [2:0] RED_MODE_MID  = 3'h1; // two pairs per cycle
  localparam logic [2:0] RED_MODE_LOW2 = 3'h2; // one pair per cycle
  localparam logic [2:0] RED_MODE_LOW3 = 3'h3; // same as 2
  localparam logic [2:0] RED_MODE_BTN  = 3'h4; // separate pushbuttons
  localparam logic [2:0] RED_MODE_HIGH = 3'h5; // all four pairs per cycle

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int         RED_POS_W     = 16;    // position counter width
  localparam logic [1:0] RED_SW_RST    = 2'h3;  // idle: both switches open
  localparam logic [15:0] RED_POS_RST  = 16'h0000;
  localparam int         RED_SYNC_N    = 3;     // synchroniser depth

  // ----------------------------------------------------------------
  // carrier for one decoded step
  // ----------------------------------------------------------------
  typedef struct packed {
    logic up;   // one-cycle up pulse
    logic down; // one-cycle down pulse
  } red_step_s;

  typedef logic [1:0] red_sw_t; // combined switch state {b,a}

endpackage : red_pkg

`default_nettype wire

// *** bench/red_enc_model.sv ***
// behavioural model of a bouncing two-switch encoder or two buttons
`default_nettype none
module red_enc_model
(
  input  wire logic clk_i,    // bench clock
  input  wire logic go_i,     // one-cycle command
  input  wire logic dir_i,    // 1 up, 0 down
  input  wire logic btn_i,    // act as two pushbuttons
  input  wire logic bounce_i, // one-cycle contact bounce
  output var  logic sw_a_o,   // switch a, pulled up
  output var  logic sw_b_o,   // switch b, pulled up
  output var  logic done_o    // ready for the next command
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph;  // phase 0..3 of the switch cycle
  logic [1:0] nst; // state being entered
  logic [1:0] ost; // state being left
  // ----------------------------------------------------------------
  // one command: a phase move, or a press and release
  // ----------------------------------------------------------------
  initial
  begin
    ph = 2'h2;
    {sw_b_o, sw_a_o} = 2'h3;
    done_o = 1'b1;
    forever
    begin
      @(posedge clk_i);
      if (go_i)
      begin
        done_o <= 1'b0;
        ost = {sw_b_o, sw_a_o};
        ph = btn_i ? ph : (dir_i ? ph + 2'h1 : ph - 2'h1);
        nst = btn_i ? (dir_i ? 2'h2 : 2'h1) : {ph[1], ph[1] ^ ph[0]};
        {sw_b_o, sw_a_o} <= nst;
        // contacts chatter once before settling
        if (bounce_i)
        begin
          @(posedge clk_i);
          {sw_b_o, sw_a_o} <= ost;
          @(posedge clk_i);
          {sw_b_o, sw_a_o} <= nst;
        end
        repeat (8) @(posedge clk_i);
        if (btn_i)
        begin
          {sw_b_o, sw_a_o} <= 2'h3;
          repeat (8) @(posedge clk_i);
        end
        done_o <= 1'b1;
      end
    end
  end
endmodule // red_enc_model
`default_nettype wire

// *** bench/red_decoder_test.sv ***
// self-checking bench for the rotary encoder decoder
`default_nettype none
module red_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  import red_pkg::*;
  logic ref_clk_i, rst_i, go, dir, btn, bnc, sw_a, sw_b, done;
  logic [2:0] mode;  // resolution setting
  red_step_s  step;  // decoded pulses
  logic [RED_POS_W-1:0] pos;
  logic [1:0] h0, h1; // last two expected phases
  int failures, comparisons, nup, ndn, eup, edn, seed;
  red_decoder dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sw_a_i(sw_a),
    .sw_b_i(sw_b), .mode_i(mode), .step_o(step), .pos_o(pos));
  red_enc_model enc_u (.clk_i(ref_clk_i), .go_i(go), .dir_i(dir),
    .btn_i(btn), .bounce_i(bnc), .sw_a_o(sw_a), .sw_b_o(sw_b),
    .done_o(done));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // a pulse held two cycles counts twice and shows as a mismatch
  always @(posedge ref_clk_i)
  begin
    if (step.up === 1'b1) nup++;
    if (step.down === 1'b1) ndn++;
  end
  function automatic logic sel(input logic [2:0] m, input logic [1:0] p);
    case (m)
      RED_MODE_MID: return !p[0];
      RED_MODE_LOW2, RED_MODE_LOW3: return p == 2'h0;
      RED_MODE_HIGH: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic end_sim();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [RED_POS_W-1:0] got, exp,
                       input string what);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic move(input logic d);
    logic [1:0] p;
    int k;
    p = d ? h0 + 2'h1 : h0 - 2'h1;
    if (btn || (sel(mode, p) && h0 - h1 == (d ? 2'h1 : 2'h3)))
      if (d) eup++; else edn++;
    if (!btn) {h1, h0} = {h0, p};
    go <= 1'b1;
    dir <= d;
    bnc <= 1'($random(seed));
    @(posedge ref_clk_i);
    go <= 1'b0;
    @(posedge ref_clk_i);
    for (k = 0; done !== 1'b1; k++)
    begin
      if (k > 60) begin failures++; end_sim(); end
      @(posedge ref_clk_i);
    end
  endtask
  task automatic run(input logic [2:0] m, input int n);
    mode <= m;
    btn <= (m == RED_MODE_BTN);
    rst_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    {nup, ndn, eup, edn} = '0;
    {h0, h1} = 4'ha;
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    check(pos, RED_POS_RST, "reset pos");
    repeat (2) begin move(1'b1); move(1'b0); end
    repeat (n) move(1'($random(seed)));
    while (h0 != 2'h2) move(1'b1);
    repeat (10) @(posedge ref_clk_i);
    check(16'(nup), 16'(eup), "up");
    check(16'(ndn), 16'(edn), "down");
    check(pos, 16'(eup - edn), "pos");
    $display("mode %0d done: %0d up %0d down", m, eup, edn);
  endtask
  initial
  begin
    {rst_i, go, dir, btn, bnc} = 5'h10;
    mode = RED_MODE_HIGH;
    seed = 32'hd74de101;
    {failures, comparisons, nup, ndn} = '0;
    for (int m = 0; m < 8; m++) run(3'(m), 40);
    end_sim();
  end
endmodule // red_decoder_test
`default_nettype wire
